// ### rtl/vacuum_monitor_value_select.sv
// Monitoring, event logging and process-data value selection of the ejector.
`timescale 1ns/1ps
module vacuum_monitor_value_select
    import vac_mon_pkg::*;
#(
    parameter int MEAS_CYC = MEAS_CYCLES
) (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic SUCTION_I,
    input wire logic [15:0] VACUUM_I,
    input wire logic [7:0] INLET_PRESSURE_I,
    input wire logic [7:0] LEAKAGE_I,
    input wire logic [7:0] SUPPLY_VOLTAGE_I,
    input wire logic [15:0] EVACUATION_TIME_I,
    input wire logic [15:0] AIR_CONSUMPTION_I,
    input wire logic [7:0] CM_FLAGS_I,
    input wire logic AUTOSET_I,
    input wire logic ERROR_EVENT_I,
    input wire logic [15:0] ERROR_CODE_I,
    input wire logic [1:0] VALUE_PAIR_SELECT_I,
    output pd_in_t PD_IN_O
);

    // ==========================================================
    // Helpers
    function automatic int ring_pos(input int wr, input int idx,
                                    input int depth);
        ring_pos = (wr + depth - 1 - idx) % depth;
    endfunction

    function automatic logic [7:0] quality_of(input logic [7:0] leak);
        if (leak >= PERCENT_FULL) begin
            quality_of = 8'h00;
        end else begin
            quality_of = PERCENT_FULL - leak;
        end
    endfunction

    function automatic logic [7:0] perf_of(input logic [15:0] dyn,
                                           input logic [15:0] thr);
        logic [31:0] num;
        num = 32'h0;
        if (dyn == 16'h0 || dyn > thr || thr == 16'h0) begin
            perf_of = 8'h00;
        end else begin
            num = 32'(thr - dyn) * 32'(PERCENT_FULL);
            perf_of = 8'(num / 32'(thr));
        end
    endfunction

    // ==========================================================
    // Suction input synchroniser and cycle counter
    logic suction_meta_r;
    logic suction_sync_r;
    logic suction_prev_r;
    logic suction_start;
    logic [15:0] cycle_count_r;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            suction_meta_r <= 1'b0;
            suction_sync_r <= 1'b0;
            suction_prev_r <= 1'b0;
        end else begin
            suction_meta_r <= SUCTION_I;
            suction_sync_r <= suction_meta_r;
            suction_prev_r <= suction_sync_r;
        end
    end

    assign suction_start = suction_sync_r && !suction_prev_r;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cycle_count_r <= 16'h0;
        end else if (suction_start) begin
            cycle_count_r <= cycle_count_r + 16'h1;
        end
    end

    // ==========================================================
    // Configuration registers
    logic [15:0] upper_vacuum_limit_r;
    logic [15:0] part_present_limit_r;
    logic [15:0] part_present_hysteresis_r;
    logic [15:0] part_threshold;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic cmd_wr;
    logic clear_diag;
    logic factory;

    assign part_threshold = part_present_limit_r - part_present_hysteresis_r;
    assign cmd_wr = wr_pend_r && wr_addr_r == OFS_CMD;
    assign factory = cmd_wr && HWDATA_I[CMD_FACTORY_BIT];
    assign clear_diag = cmd_wr && (HWDATA_I[CMD_CLEAR_DIAG_BIT] || factory);

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            upper_vacuum_limit_r <= UPPER_LIMIT_RST;
            part_present_limit_r <= PART_LIMIT_RST;
            part_present_hysteresis_r <= PART_HYST_RST;
        end else if (factory) begin
            upper_vacuum_limit_r <= UPPER_LIMIT_RST;
            part_present_limit_r <= PART_LIMIT_RST;
            part_present_hysteresis_r <= PART_HYST_RST;
        end else if (wr_pend_r && wr_addr_r == OFS_LIMITS) begin
            upper_vacuum_limit_r <= HWDATA_I[15:0];
            part_present_limit_r <= HWDATA_I[31:16];
        end else if (wr_pend_r && wr_addr_r == OFS_HYST) begin
            part_present_hysteresis_r <= HWDATA_I[15:0];
        end
    end

    // ==========================================================
    // Dynamic pressure measurement
    // A part laid on the cup before the second is over cuts suction short,
    // so the window simply restarts with the next suction cycle.
    logic [31:0] meas_cnt_r;
    logic meas_run_r;
    logic meas_done;
    logic meas_ok;
    logic meas_event;
    logic [15:0] dyn_pressure_r;
    logic dyn_known_r;
    logic dyn_warn_r;

    assign meas_done = meas_run_r && suction_sync_r
                       && meas_cnt_r == 32'(MEAS_CYC - 1);
    assign meas_ok = VACUUM_I >= DYN_MIN_MBAR
                     && VACUUM_I <= upper_vacuum_limit_r;
    assign meas_event = meas_done && VACUUM_I > part_threshold
                        && VACUUM_I < upper_vacuum_limit_r;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            meas_run_r <= 1'b0;
            meas_cnt_r <= 32'h0;
        end else if (suction_start) begin
            meas_run_r <= 1'b1;
            meas_cnt_r <= 32'h0;
        end else if (!suction_sync_r || meas_done) begin
            meas_run_r <= 1'b0;
            meas_cnt_r <= 32'h0;
        end else if (meas_run_r) begin
            meas_cnt_r <= meas_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            dyn_pressure_r <= 16'h0;
            dyn_known_r <= 1'b0;
        end else if (meas_done && meas_ok) begin
            dyn_pressure_r <= VACUUM_I;
            dyn_known_r <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            dyn_warn_r <= 1'b0;
        end else if (meas_done) begin
            dyn_warn_r <= meas_event;
        end
    end

    // ==========================================================
    // Ratings
    logic [7:0] quality;
    logic [7:0] perf;

    assign quality = quality_of(LEAKAGE_I);
    assign perf = !dyn_known_r ? PERF_UNKNOWN
                  : perf_of(dyn_pressure_r, part_threshold);

    // ==========================================================
    // Diagnostic log
    // The arrays carry no reset so that their contents outlive a reset;
    // true power-loss retention needs the non-volatile store behind them.
    diag_rec_t diag_mem [DIAG_DEPTH];
    logic [5:0] diag_wr_r;
    logic [5:0] diag_cnt_r;
    logic [5:0] diag_idx_r;
    logic dyn_evt_pend_r;
    logic diag_we;
    diag_rec_t diag_new;
    diag_rec_t diag_rd;
    logic [5:0] diag_base;

    assign diag_we = ERROR_EVENT_I || dyn_evt_pend_r;
    assign diag_new.code = ERROR_EVENT_I ? ERROR_CODE_I : DIAG_CODE_DYN;
    assign diag_new.cycles = cycle_count_r;
    assign diag_base = clear_diag ? 6'h0 : diag_wr_r;
    assign diag_rd = diag_idx_r < diag_cnt_r
        ? diag_mem[ring_pos(int'(diag_wr_r), int'(diag_idx_r), DIAG_DEPTH)]
        : '0;

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            dyn_evt_pend_r <= 1'b0;
        end else if (meas_event) begin
            dyn_evt_pend_r <= 1'b1;
        end else if (!ERROR_EVENT_I) begin
            dyn_evt_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (diag_we) begin
            diag_mem[diag_base] <= diag_new;
        end
    end

    // An event in the clearing cycle lands as the first entry of the new log.
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            diag_wr_r <= 6'h0;
            diag_cnt_r <= 6'h0;
        end else begin
            if (diag_we) begin
                diag_wr_r <= (diag_base == 6'(DIAG_DEPTH - 1))
                             ? 6'h0 : diag_base + 6'h1;
            end else begin
                diag_wr_r <= diag_base;
            end
            if (clear_diag) begin
                diag_cnt_r <= diag_we ? 6'h1 : 6'h0;
            end else if (diag_we && diag_cnt_r != 6'(DIAG_DEPTH)) begin
                diag_cnt_r <= diag_cnt_r + 6'h1;
            end
        end
    end

    // ==========================================================
    // Key-figure buffer
    kf_rec_t kf_mem [KF_DEPTH];
    logic [3:0] kf_wr_r;
    logic [3:0] kf_cnt_r;
    logic [3:0] kf_idx_r;
    kf_rec_t kf_new;
    kf_rec_t kf_rd;

    assign kf_new.evacuation_time = EVACUATION_TIME_I;
    assign kf_new.leakage = {8'h00, LEAKAGE_I};
    assign kf_new.dyn_pressure = dyn_pressure_r;
    assign kf_new.cycles = cycle_count_r;
    assign kf_rd = kf_idx_r < kf_cnt_r
        ? kf_mem[ring_pos(int'(kf_wr_r), int'(kf_idx_r), KF_DEPTH)]
        : '0;

    always_ff @(posedge REF_CLK_I) begin
        if (AUTOSET_I) begin
            kf_mem[kf_wr_r] <= kf_new;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            kf_wr_r <= 4'h0;
            kf_cnt_r <= 4'h0;
        end else if (AUTOSET_I) begin
            kf_wr_r <= (kf_wr_r == 4'(KF_DEPTH - 1))
                       ? 4'h0 : kf_wr_r + 4'h1;
            if (kf_cnt_r != 4'(KF_DEPTH)) begin
                kf_cnt_r <= kf_cnt_r + 4'h1;
            end
        end
    end

    // ==========================================================
    // Process data value selection
    logic [1:0] sel_applied_r;
    logic [2:0] sel_wait_r;
    logic sel_take;
    logic [1:0] sel_eff;
    logic [7:0] byte_mux;
    logic [15:0] word_mux;

    assign sel_take = VALUE_PAIR_SELECT_I != sel_applied_r
                      && sel_wait_r == 3'(SEL_DELAY_CYCLES - 1);
    assign sel_eff = sel_take ? VALUE_PAIR_SELECT_I : sel_applied_r;

    always_comb begin
        case (sel_eff)
            SEL_BASE: begin
                byte_mux = INLET_PRESSURE_I;
                word_mux = VACUUM_I;
            end
            SEL_CM: begin
                byte_mux = {CM_FLAGS_I[7:1], dyn_warn_r};
                word_mux = EVACUATION_TIME_I;
            end
            SEL_LEAK: begin
                byte_mux = LEAKAGE_I;
                word_mux = dyn_pressure_r;
            end
            SEL_ENERGY: begin
                byte_mux = SUPPLY_VOLTAGE_I;
                word_mux = AIR_CONSUMPTION_I;
            end
            default: begin
                byte_mux = 8'h00;
                word_mux = 16'h0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            sel_applied_r <= SEL_BASE;
            sel_wait_r <= 3'h0;
        end else begin
            sel_applied_r <= sel_eff;
            if (VALUE_PAIR_SELECT_I == sel_applied_r || sel_take) begin
                sel_wait_r <= 3'h0;
            end else begin
                sel_wait_r <= sel_wait_r + 3'h1;
            end
        end
    end

    // Slots and acknowledge load from one select value in one edge.
    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            PD_IN_O <= '0;
        end else begin
            PD_IN_O.byte_value_slot <= byte_mux;
            PD_IN_O.word_value_slot <= word_mux;
            PD_IN_O.ack <= sel_eff != SEL_BASE;
        end
    end

    // ==========================================================
    // AHB-Lite slave
    logic addr_ok;
    logic [31:0] rd_mux;

    assign addr_ok = HSEL_I && HREADY_I && HTRANS_I[1];
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;

    always_comb begin
        case (HADDR_I[7:0])
            OFS_LIMITS: rd_mux = {part_present_limit_r, upper_vacuum_limit_r};
            OFS_HYST: rd_mux = {16'h0, part_present_hysteresis_r};
            OFS_RATING: rd_mux = {quality, perf, dyn_pressure_r};
            OFS_INFO: rd_mux = {cycle_count_r[7:0], 2'b00, diag_cnt_r,
                                4'h0, kf_cnt_r, 6'h0, dyn_warn_r, dyn_known_r};
            OFS_DIAG_IDX: rd_mux = {26'h0, diag_idx_r};
            OFS_DIAG_DATA: rd_mux = diag_rd;
            OFS_KF_IDX: rd_mux = {28'h0, kf_idx_r};
            OFS_KF_DATA0: rd_mux = {kf_rd.evacuation_time, kf_rd.leakage};
            OFS_KF_DATA1: rd_mux = {kf_rd.dyn_pressure, kf_rd.cycles};
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            HRDATA_O <= 32'h0;
        end else begin
            wr_pend_r <= addr_ok && HWRITE_I;
            wr_addr_r <= HADDR_I[7:0];
            if (addr_ok && !HWRITE_I) begin
                HRDATA_O <= HADDR_I[31:8] == 24'h0 ? rd_mux : 32'h0;
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            diag_idx_r <= 6'h0;
            kf_idx_r <= 4'h0;
        end else if (wr_pend_r && wr_addr_r == OFS_DIAG_IDX) begin
            diag_idx_r <= HWDATA_I[5:0];
        end else if (wr_pend_r && wr_addr_r == OFS_KF_IDX) begin
            kf_idx_r <= HWDATA_I[3:0];
        end
    end

endmodule

// ### rtl/vac_mon_pkg.sv
// Package with constants, register map and types for the vacuum monitor.
// Notes on behaviour
// - Dynamic pressure sampled after one second of uninterrupted suction.
// - Readings under 5 mbar or above upper limit rejected; last result kept.
// - Reading above part-present limit minus hysteresis, below upper, is event.
// - Dynamic pressure and performance unknown after power-up; held till next.
// - Quality rating falls as leakage rises.
// - Performance rating rises as dynamic pressure falls.
// - Performance zero when dynamic pressure exceeds part-present threshold.
// - Stored dynamic pressure zero means no measurement; performance reads FFh (unknown).
// - Diagnostic log keeps latest 38 events, read newest first.
// - Each logged event stores the current suction cycle count.
// - Logging runs in every mode; array kept across reset, but reset zeroes the entry count, so the log reads empty.
// - Log erased by clear command and by factory restore.
// - Ten key-figure records of evacuation time, leakage, dynamic pressure.
// - A key-figure record is written only on condition-monitoring autoset.
// - Each key-figure record carries the suction cycle count; reset zeroes the record count, so the buffer reads empty.
// - Process input area holds one byte slot and one word slot.
// - Controller drives the two-bit select; device follows it.
// - Byte slot: inlet pressure, monitoring flags, leakage, supply voltage.
// - Word slot: vacuum, evacuation time, dynamic pressure, air consumption.
// - New select applied after a delay; ack is 0 for 00, else 1.
// - Measurement tried at every suction start, compared to both limits.
package vac_mon_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFS_LIMITS = 8'h00;
    localparam logic [7:0] OFS_HYST = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_RATING = 8'h0C;
    localparam logic [7:0] OFS_INFO = 8'h10;
    localparam logic [7:0] OFS_DIAG_IDX = 8'h14;
    localparam logic [7:0] OFS_DIAG_DATA = 8'h18;
    localparam logic [7:0] OFS_KF_IDX = 8'h1C;
    localparam logic [7:0] OFS_KF_DATA0 = 8'h20;
    localparam logic [7:0] OFS_KF_DATA1 = 8'h24;
    localparam int CMD_CLEAR_DIAG_BIT = 0;
    localparam int CMD_FACTORY_BIT = 1;

    // ==========================================================
    // Reset values and limits
    localparam logic [15:0] UPPER_LIMIT_RST = 16'h02EE;
    localparam logic [15:0] PART_LIMIT_RST = 16'h0226;
    localparam logic [15:0] PART_HYST_RST = 16'h000A;
    localparam logic [15:0] DYN_MIN_MBAR = 16'h0005;
    localparam logic [7:0] PERCENT_FULL = 8'h64;
    localparam logic [7:0] PERF_UNKNOWN = 8'hFF;
    localparam logic [15:0] DIAG_CODE_DYN = 16'h0001;

    // ==========================================================
    // Buffers, selection and timing
    localparam int DIAG_DEPTH = 38;
    localparam int KF_DEPTH = 10;
    localparam logic [1:0] SEL_BASE = 2'b00;
    localparam logic [1:0] SEL_CM = 2'b01;
    localparam logic [1:0] SEL_LEAK = 2'b10;
    localparam logic [1:0] SEL_ENERGY = 2'b11;
    localparam int CLK_HZ = 50_000_000;
    localparam int MEAS_TIME_MS = 1000;
    localparam int MEAS_CYCLES = CLK_HZ / 1000 * MEAS_TIME_MS;
    localparam int SEL_DELAY_CYCLES = 4;

    // ==========================================================
    // Types
    typedef struct packed {
        logic ack;
        logic [7:0] byte_value_slot;
        logic [15:0] word_value_slot;
    } pd_in_t;

    typedef struct packed {
        logic [15:0] code;
        logic [15:0] cycles;
    } diag_rec_t;

    typedef struct packed {
        logic [15:0] evacuation_time;
        logic [15:0] leakage;
        logic [15:0] dyn_pressure;
        logic [15:0] cycles;
    } kf_rec_t;

endpackage

// ### sim/vac_mon_assertions.sv
// Checker for the vacuum monitor: value selection, ratings and counts.
`timescale 1ns/1ps
module vac_mon_assertions
    import vac_mon_pkg::*;
#(
    parameter int MEAS_CYC = MEAS_CYCLES
) (
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic [15:0] VACUUM_I,
    input wire logic [7:0] INLET_PRESSURE_I,
    input wire logic [7:0] LEAKAGE_I,
    input wire logic [7:0] SUPPLY_VOLTAGE_I,
    input wire logic [15:0] EVACUATION_TIME_I,
    input wire logic [15:0] AIR_CONSUMPTION_I,
    input wire logic [7:0] CM_FLAGS_I,
    input wire logic [1:0] VALUE_PAIR_SELECT_I,
    input wire pd_in_t PD_IN_O
);
    // ==========
    // Expected slots. Dynamic pressure and the warn bit are internal.
    localparam logic [15:0] THR = PART_LIMIT_RST - PART_HYST_RST;
    logic [23:0] mx;
    logic [23:0] msk;
    logic [7:0] qx;
    always_comb begin
        case (VALUE_PAIR_SELECT_I)
            SEL_BASE: mx = {INLET_PRESSURE_I, VACUUM_I};
            SEL_CM: mx = {CM_FLAGS_I, EVACUATION_TIME_I};
            SEL_LEAK: mx = {LEAKAGE_I, 16'h0000};
            default: mx = {SUPPLY_VOLTAGE_I, AIR_CONSUMPTION_I};
        endcase
    end
    assign msk = (VALUE_PAIR_SELECT_I == SEL_CM) ? 24'hFEFFFF :
        (VALUE_PAIR_SELECT_I == SEL_LEAK) ? 24'hFF0000 : 24'hFFFFFF;
    assign qx = (LEAKAGE_I >= PERCENT_FULL) ? 8'h00 : PERCENT_FULL - LEAKAGE_I;
    // ==========
    // Properties
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    sequence sel_held;
        $stable(VALUE_PAIR_SELECT_I) [*8];
    endsequence
    sequence rd(logic [7:0] a);
        HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I
            && HADDR_I == {24'h0, a};
    endsequence
    a_ack_follows_sel: assert property (
        sel_held |-> PD_IN_O.ack == (VALUE_PAIR_SELECT_I != SEL_BASE))
        else $error("ack does not match the held select");
    a_byte_slot_mux: assert property (
        sel_held |-> (PD_IN_O[23:16] & msk[23:16])
            == ($past(mx[23:16]) & msk[23:16]))
        else $error("byte slot does not carry the selected value");
    a_word_slot_mux: assert property (
        sel_held |-> (PD_IN_O[15:0] & msk[15:0])
            == ($past(mx[15:0]) & msk[15:0]))
        else $error("word slot does not carry the selected value");
    a_ack_not_early: assert property (
        $changed(VALUE_PAIR_SELECT_I) |=> $stable(PD_IN_O.ack) [*3])
        else $error("ack moved before the select delay");
    a_ack_with_slots: assert property (
        $changed(PD_IN_O.ack) |-> (PD_IN_O[23:0] & msk) == ($past(mx) & msk))
        else $error("ack changed before the slots took new contents");
    a_perf_in_range: assert property (
        rd(OFS_RATING) |=> HRDATA_O[23:16] <= PERCENT_FULL ||
            HRDATA_O[23:16] == PERF_UNKNOWN)
        else $error("performance outside its range");
    a_perf_zero_high: assert property (
        rd(OFS_RATING) |=> HRDATA_O[15:0] <= THR || HRDATA_O[23:16] == 8'h00)
        else $error("performance not zero for high dynamic pressure");
    a_quality_leak: assert property (
        rd(OFS_RATING) ##1 $stable(LEAKAGE_I) |-> HRDATA_O[31:24] == $past(qx))
        else $error("quality does not fall with leakage");
    a_diag_count_cap: assert property (
        rd(OFS_INFO) |=> HRDATA_O[21:16] <= 6'h26)
        else $error("diagnostic count above its depth");
    a_kf_count_cap: assert property (
        rd(OFS_INFO) |=> HRDATA_O[11:8] <= 4'hA)
        else $error("key-figure count above its depth");
endmodule

bind vacuum_monitor_value_select vac_mon_assertions #(.MEAS_CYC(MEAS_CYC))
    chk_u (.REF_CLK_I(REF_CLK_I), .RESET_N_I(RESET_N_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .VACUUM_I(VACUUM_I),
    .INLET_PRESSURE_I(INLET_PRESSURE_I), .LEAKAGE_I(LEAKAGE_I),
    .SUPPLY_VOLTAGE_I(SUPPLY_VOLTAGE_I), .CM_FLAGS_I(CM_FLAGS_I),
    .EVACUATION_TIME_I(EVACUATION_TIME_I), .PD_IN_O(PD_IN_O),
    .AIR_CONSUMPTION_I(AIR_CONSUMPTION_I),
    .VALUE_PAIR_SELECT_I(VALUE_PAIR_SELECT_I));

// ### sim/ctl_model.sv
// Controller-side model that fetches value pairs by the select handshake.
`timescale 1ns/1ps
module ctl_model
    import vac_mon_pkg::*;
(
    input wire logic clk_i,
    input wire pd_in_t pd_i,
    output logic [1:0] sel_o
);
    // ==========
    // Fetch; dwell lets a slow controller sit on the acknowledged pair.
    initial sel_o = SEL_BASE;
    task automatic fetch(input logic [1:0] s, input int dwell,
                         output pd_in_t v, output logic to);
        int k;
        sel_o <= s;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_i);
            #1;
            if (pd_i.ack === (s != SEL_BASE)) break;
        end
        to = (k == 40);
        repeat (dwell) @(posedge clk_i);
        #1;
        v = pd_i;
        sel_o <= SEL_BASE;
        for (k = 0; k < 40; k++) begin
            @(posedge clk_i);
            #1;
            if (pd_i.ack === 1'b0) break;
        end
        to = to | (k == 40);
    endtask
endmodule

// ### sim/tb.sv
// Self-checking bench for the vacuum monitor and its value selection.
`timescale 1ns/1ps
module tb;
    import vac_mon_pkg::*;
    localparam int MC = 20;
    localparam int THR = int'(PART_LIMIT_RST) - int'(PART_HYST_RST);
    logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hready, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [1:0] htrans = 0, sel;
    logic suction = 0, autoset = 0, err = 0;
    logic [15:0] vac = 0, evac = 16'h0123, air = 16'h0BCD, ecode = 0;
    logic [7:0] inlet = 8'h11, leak = 8'h1E, volt = 8'hF0, cm = 8'hA4;
    pd_in_t pd;
    int n_fail = 0, compares = 0, ncyc = 0;
    always #10 clk = ~clk;
    vacuum_monitor_value_select #(.MEAS_CYC(MC)) dut_u (
        .REF_CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .SUCTION_I(suction),
        .VACUUM_I(vac), .INLET_PRESSURE_I(inlet), .LEAKAGE_I(leak),
        .SUPPLY_VOLTAGE_I(volt), .EVACUATION_TIME_I(evac),
        .AIR_CONSUMPTION_I(air), .CM_FLAGS_I(cm), .AUTOSET_I(autoset),
        .ERROR_EVENT_I(err), .ERROR_CODE_I(ecode),
        .VALUE_PAIR_SELECT_I(sel), .PD_IN_O(pd));
    ctl_model ctl_u (.clk_i(clk), .pd_i(pd), .sel_o(sel));
    // ==========
    // Common tasks
    task automatic results();
        $display("checks %0d failures %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrdy();
        int k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (k == 50) begin
            n_fail++;
            results();
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        wrdy();
        htrans <= 2'b00;
        hwdata <= d;
        wrdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, {24'h0, a}, d, q);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] m, e);
        logic [31:0] q;
        bus(1'b0, {24'h0, a}, 32'h0, q);
        chk(nm, q & m, e);
    endtask
    task automatic suck(input logic [15:0] v, input int n);
        vac <= v;
        suction <= 1'b1;
        ncyc++;
        repeat (n) @(posedge clk);
        suction <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // ==========
    // Scenarios
    task automatic t_meas();
        rdc("unknown perf", OFS_RATING, 32'h00FF0000, 32'h00FF0000);
        rdc("known flag", OFS_INFO, 32'h1, 32'h0);
        suck(16'd100, MC + 8);
        rdc("rating", OFS_RATING, '1,
            {8'h46, 8'((THR - 100) * 100 / THR), 16'd100});
        suck(16'd50, MC - 10);
        rdc("short", OFS_RATING, 32'hFFFF, 32'd100);
        suck(16'd3, MC + 8);
        rdc("low", OFS_RATING, 32'hFFFF, 32'd100);
        suck(16'd800, MC + 8);
        rdc("high", OFS_RATING, 32'hFFFF, 32'd100);
        rdc("no event", OFS_INFO, 32'h003F0002, 32'h0);
        suck(16'd600, MC + 8);
        rdc("warn", OFS_RATING, '1, {8'h46, 8'h00, 16'd600});
        rdc("event", OFS_INFO, 32'h003F0003, 32'h00010003);
        wr(OFS_DIAG_IDX, 32'h0);
        rdc("entry", OFS_DIAG_DATA, '1, {DIAG_CODE_DYN, 16'(ncyc)});
    endtask
    task automatic t_sel();
        pd_in_t v;
        logic to;
        logic [23:0] e [4];
        e[0] = {inlet, vac};
        e[1] = {cm | 8'h01, evac};
        e[2] = {leak, 16'd600};
        e[3] = {volt, air};
        for (int s = 0; s < 4; s++) begin
            ctl_u.fetch(2'(s), s + 5, v, to);
            chk("handshake", 32'(to), 32'h0);
            chk("ack", 32'(v.ack), 32'(s != 0));
            chk("byte", 32'(v[23:16]), 32'(e[s][23:16]));
            chk("word", 32'(v[15:0]), 32'(e[s][15:0]));
        end
    endtask
    task automatic t_kf();
        rdc("kf none", OFS_INFO, 32'hF00, 32'h0);
        autoset <= 1'b1;
        @(posedge clk);
        autoset <= 1'b0;
        rdc("kf one", OFS_INFO, 32'hF00, 32'h100);
        wr(OFS_KF_IDX, 32'h0);
        rdc("kf0", OFS_KF_DATA0, '1, {evac, 8'h00, leak});
        rdc("kf1", OFS_KF_DATA1, '1, {16'd600, 16'(ncyc)});
        autoset <= 1'b1;
        repeat (11) @(posedge clk);
        autoset <= 1'b0;
        rdc("kf full", OFS_INFO, 32'hF00, 32'hA00);
    endtask
    task automatic t_diag();
        wr(OFS_CMD, 32'h1);
        rdc("cleared", OFS_INFO, 32'h3F0000, 32'h0);
        err <= 1'b1;
        for (int i = 1; i <= 40; i++) begin
            ecode <= 16'(i);
            @(posedge clk);
        end
        err <= 1'b0;
        rdc("diag cnt", OFS_INFO, 32'h3F0000, 32'h260000);
        wr(OFS_DIAG_IDX, 32'h0);
        rdc("newest", OFS_DIAG_DATA, '1, {16'd40, 16'(ncyc)});
        wr(OFS_DIAG_IDX, 32'd37);
        rdc("oldest", OFS_DIAG_DATA, 32'hFFFF0000, 32'h00030000);
        wr(OFS_LIMITS, 32'h03000400);
        wr(OFS_CMD, 32'h2);
        rdc("factory", OFS_INFO, 32'h3F0000, 32'h0);
        rdc("lim", OFS_LIMITS, '1, {PART_LIMIT_RST, UPPER_LIMIT_RST});
        rdc("hyst", OFS_HYST, 32'hFFFF, {16'h0, PART_HYST_RST});
    endtask
    // ==========
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_meas();
        t_sel();
        t_kf();
        t_diag();
        results();
    end
endmodule
